// file: sod_dmem.sv
module sod_dmem #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  // Clock
  input  wire logic              clk,
  // Port
  input  wire logic              re,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Synchronous write, registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule // sod_dmem

// file: sod_pkg.sv
package sod_pkg;

  // Widths
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_ACC    = 8'h00;
  localparam logic [7:0] OFS_BANK   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_INDEX  = 8'h10;
  localparam logic [7:0] OFS_INSTR  = 8'h14;
  localparam logic [7:0] OFS_MADDR  = 8'h18;
  localparam logic [7:0] OFS_MDATA  = 8'h1C;

  // Reset values
  localparam logic [7:0]        RST_ACC   = 8'h00;
  localparam logic [BANK_W-1:0] RST_BANK  = 4'h0;
  localparam logic [4:0]        RST_FLAGS = 5'h00;
  localparam logic              RST_EXT   = 1'b0;
  localparam logic [ADDR_W-1:0] RST_INDEX = 12'h000;
  localparam logic [ADDR_W-1:0] RST_MADDR = 12'h000;

  // Status flag positions
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;

  // Control field position
  localparam int CTRL_EXT = 0;

  // Instruction word fields
  localparam logic [7:0] OPC_LIT   = 8'h08;
  localparam logic [5:0] OPC_FILE  = 6'h17;
  localparam int         DEST_BIT  = 9;
  localparam int         ACC_BIT   = 8;

  // Access bank layout
  localparam logic [7:0]        ILO_LIMIT  = 8'h5F;
  localparam logic [BANK_W-1:0] ACC_HI_BNK = 4'hF;
  localparam logic [BANK_W-1:0] ACC_LO_BNK = 4'h0;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } sod_state_t;

  // Result of one subtraction with its flags
  typedef struct packed {
    logic [7:0] res;
    logic       n;
    logic       ov;
    logic       z;
    logic       dc;
    logic       c;
  } sod_sub_t;

  // Two's complement a - b; carry set means no borrow
  function automatic sod_sub_t sod_subtract(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    sod_sub_t   r;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    r.res = full[7:0];
    r.c   = full[8];
    r.dc  = low[4];
    r.n   = full[7];
    r.z   = (full[7:0] == 8'h00);
    r.ov  = (a[7] != b[7]) && (full[7] != a[7]);
    return r;
  endfunction

  // Flag vector in status layout
  function automatic logic [4:0] sod_flags(input sod_sub_t r);
    logic [4:0] f;
    f         = 5'h00;
    f[FLG_C]  = r.c;
    f[FLG_DC] = r.dc;
    f[FLG_Z]  = r.z;
    f[FLG_OV] = r.ov;
    f[FLG_N]  = r.n;
    return f;
  endfunction

  // Data memory address of a file operand
  function automatic logic [ADDR_W-1:0] sod_file_addr(input logic [7:0] f, input logic a, input logic ext,
                                                     input logic [BANK_W-1:0] bank,
                                                     input logic [ADDR_W-1:0] index);
    logic [ADDR_W-1:0] r;
    if (a) begin
      r = {bank, f};
    end else if (ext && (f <= ILO_LIMIT)) begin
      r = index + {4'h0, f};
    end else if (f <= ILO_LIMIT) begin
      r = {ACC_LO_BNK, f};
    end else begin
      r = {ACC_HI_BNK, f};
    end
    return r;
  endfunction

endpackage

// file: sod_top.sv
// The APB slave port and the address map were chosen for this implementation.
module sod_top
  import sod_pkg::*;
#(
  parameter int MEM_AW = ADDR_W
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        SRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  // State
  sod_state_t        state_reg, state_next;
  logic [7:0]        acc_reg, acc_next;
  logic [BANK_W-1:0] bank_reg, bank_next;
  logic [4:0]        flags_reg, flags_next;
  logic              ext_reg, ext_next;
  logic [ADDR_W-1:0] index_reg, index_next;
  logic [ADDR_W-1:0] maddr_reg, maddr_next;
  logic [ADDR_W-1:0] waddr_reg, waddr_next;
  logic              dest_reg, dest_next;
  logic              rd_pend_reg, rd_pend_next;
  logic              rd_mem_reg, rd_mem_next;
  logic [31:0]       prdata_reg, prdata_next;

  // Decode
  logic              access;
  logic              idle;
  logic              wr_go;
  logic              instr_go;
  logic              lit_go;
  logic              file_go;
  logic              rd_start;
  logic              mapped;
  logic              core_wb;
  logic [ADDR_W-1:0] file_addr;
  sod_sub_t          lres;
  sod_sub_t          fres;

  // Memory port
  logic              mem_re;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0]        mem_wdata;
  logic [7:0]        mem_rdata;

  // Bus phase and instruction decode
  assign access    = PSEL & PENABLE;
  assign idle      = (state_reg == ST_IDLE);
  assign wr_go     = access & PWRITE & idle;
  assign instr_go  = wr_go & (PADDR == OFS_INSTR);
  assign lit_go    = instr_go & (PWDATA[15:8] == OPC_LIT);
  assign file_go   = instr_go & (PWDATA[15:10] == OPC_FILE);
  assign rd_start  = access & ~PWRITE & idle & ~rd_pend_reg;
  assign core_wb   = (state_reg == ST_EXEC) & dest_reg;
  // Operand address: access bank, banked, or indexed
  // address resolution
  assign file_addr = sod_file_addr(PWDATA[7:0], PWDATA[ACC_BIT], ext_reg, bank_reg, index_reg);
  // Both subtractors
  assign lres      = sod_subtract(PWDATA[7:0], acc_reg);
  assign fres      = sod_subtract(mem_rdata, acc_reg);

  // Address map check
  always_comb begin
    unique case (PADDR)
      OFS_ACC, OFS_BANK, OFS_STATUS, OFS_CTRL,
      OFS_INDEX, OFS_INSTR, OFS_MADDR, OFS_MDATA: mapped = 1'b1;
      default:                                    mapped = 1'b0;
    endcase
  end

  // Bus answer: writes at once when idle, reads one wait state
  assign PREADY  = idle & (PWRITE | rd_pend_reg);
  assign PSLVERR = PREADY & access & (~mapped | ((PADDR == OFS_INSTR) & PWRITE & ~lit_go & ~file_go));
  assign PRDATA  = rd_mem_reg ? {24'h000000, mem_rdata} : prdata_reg;

  // Memory port sharing, core writeback first
  // writeback to file register
  assign mem_we    = core_wb | (wr_go & (PADDR == OFS_MDATA));
  assign mem_re    = file_go | (rd_start & (PADDR == OFS_MDATA));
  assign mem_addr  = core_wb ? waddr_reg : (file_go ? file_addr : maddr_reg);
  assign mem_wdata = core_wb ? fres.res : PWDATA[7:0];

  sod_dmem #(
    .ADDR_W (MEM_AW),
    .DATA_W (8)
  ) u_dmem (
    .clk   (MCLK),
    .re    (mem_re),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Next state of registers and sequencer
  always_comb begin
    state_next   = state_reg;
    acc_next     = acc_reg;
    bank_next    = bank_reg;
    flags_next   = flags_reg;
    ext_next     = ext_reg;
    index_next   = index_reg;
    maddr_next   = maddr_reg;
    waddr_next   = waddr_reg;
    dest_next    = dest_reg;
    rd_pend_next = rd_start;
    rd_mem_next  = rd_start & (PADDR == OFS_MDATA);
    prdata_next  = prdata_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (wr_go) begin
          unique case (PADDR)
            OFS_ACC:    acc_next   = PWDATA[7:0];
            OFS_BANK:   bank_next  = PWDATA[BANK_W-1:0];
            OFS_STATUS: flags_next = PWDATA[4:0];
            OFS_CTRL:   ext_next   = PWDATA[CTRL_EXT];
            OFS_INDEX:  index_next = PWDATA[ADDR_W-1:0];
            OFS_MADDR:  maddr_next = PWDATA[ADDR_W-1:0];
            default: ;
          endcase
        end
        if (lit_go) begin
          acc_next   = lres.res;
          flags_next = sod_flags(lres);
        end
        // File subtract waits for the operand read
        if (file_go) begin
          state_next = ST_EXEC;
          dest_next  = PWDATA[DEST_BIT];
          waddr_next = file_addr;
        end
        if (rd_start) begin
          unique case (PADDR)
            OFS_ACC:    prdata_next = {24'h000000, acc_reg};
            OFS_BANK:   prdata_next = {28'h0000000, bank_reg};
            OFS_STATUS: prdata_next = {27'h0000000, flags_reg};
            OFS_CTRL:   prdata_next = {31'h00000000, ext_reg};
            OFS_INDEX:  prdata_next = {20'h00000, index_reg};
            OFS_MADDR:  prdata_next = {20'h00000, maddr_reg};
            default:    prdata_next = 32'h00000000;
          endcase
        end
      end
      ST_EXEC: begin
        flags_next = sod_flags(fres);
        if (!dest_reg) begin
          acc_next = fres.res;
        end
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_reg   <= ST_IDLE;
      acc_reg     <= RST_ACC;
      bank_reg    <= RST_BANK;
      flags_reg   <= RST_FLAGS;
      ext_reg     <= RST_EXT;
      index_reg   <= RST_INDEX;
      maddr_reg   <= RST_MADDR;
      waddr_reg   <= RST_MADDR;
      dest_reg    <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_mem_reg  <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      state_reg   <= state_next;
      acc_reg     <= acc_next;
      bank_reg    <= bank_next;
      flags_reg   <= flags_next;
      ext_reg     <= ext_next;
      index_reg   <= index_next;
      maddr_reg   <= maddr_next;
      waddr_reg   <= waddr_next;
      dest_reg    <= dest_next;
      rd_pend_reg <= rd_pend_next;
      rd_mem_reg  <= rd_mem_next;
      prdata_reg  <= prdata_next;
    end
  end

  // Checks on the datapath
  property p_lit_res;
    @(posedge MCLK) disable iff (SRST) lit_go |=> (acc_reg == 8'($past(PWDATA[7:0]) - $past(acc_reg)));
  endproperty
  a_lit_res: assert property (p_lit_res) else $error("literal result wrong");

  property p_lit_carry;
    @(posedge MCLK) disable iff (SRST)
      lit_go |=> (flags_reg[FLG_C] == ($past(PWDATA[7:0]) >= $past(acc_reg))) && (flags_reg[FLG_Z] == (acc_reg == 8'h00));
  endproperty
  a_lit_carry: assert property (p_lit_carry) else $error("literal carry or zero wrong");

  property p_file_acc;
    @(posedge MCLK) disable iff (SRST)
      (state_reg == ST_EXEC) && !dest_reg |=> (acc_reg == 8'($past(mem_rdata) - $past(acc_reg)));
  endproperty
  a_file_acc: assert property (p_file_acc) else $error("file result to accumulator wrong");

  property p_dest0;
    @(posedge MCLK) disable iff (SRST) (state_reg == ST_EXEC) && !dest_reg |-> !mem_we;
  endproperty
  a_dest0: assert property (p_dest0) else $error("file register written with destination zero");

  property p_dest1;
    @(posedge MCLK) disable iff (SRST)
      file_go && PWDATA[DEST_BIT] |=> mem_we && (mem_addr == $past(file_addr))
                                      && (mem_wdata == 8'(mem_rdata - acc_reg)) ##1 (acc_reg == $past(acc_reg));
  endproperty
  a_dest1: assert property (p_dest1) else $error("writeback to file register wrong");

  property p_access;
    @(posedge MCLK) disable iff (SRST)
      file_go && !PWDATA[ACC_BIT] && !(ext_reg && (PWDATA[7:0] <= ILO_LIMIT))
        |-> (mem_addr[7:0] == PWDATA[7:0]) && (mem_addr[11:8] == ((PWDATA[7:0] <= ILO_LIMIT) ? ACC_LO_BNK : ACC_HI_BNK));
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_bank;
    @(posedge MCLK) disable iff (SRST) file_go && PWDATA[ACC_BIT] |-> (mem_addr == {bank_reg, PWDATA[7:0]});
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_index;
    @(posedge MCLK) disable iff (SRST)
      file_go && !PWDATA[ACC_BIT] && ext_reg && (PWDATA[7:0] <= ILO_LIMIT)
        |-> (mem_addr == 12'(index_reg + {4'h0, PWDATA[7:0]}));
  endproperty
  a_index: assert property (p_index) else $error("indexed address wrong");

  property p_exec_one;
    @(posedge MCLK) disable iff (SRST) (state_reg == ST_EXEC) |=> (state_reg == ST_IDLE);
  endproperty
  a_exec_one: assert property (p_exec_one) else $error("file subtract longer than one execute cycle");

  c_lit:   cover property (@(posedge MCLK) disable iff (SRST) lit_go);
  c_dest0: cover property (@(posedge MCLK) disable iff (SRST) file_go && !PWDATA[DEST_BIT]);
  c_dest1: cover property (@(posedge MCLK) disable iff (SRST) file_go && PWDATA[DEST_BIT]);
  c_index: cover property (@(posedge MCLK) disable iff (SRST) file_go && !PWDATA[ACC_BIT] && ext_reg);

endmodule // sod_top

// file: subtract_operand_datapath_tb.sv
module subtract_operand_datapath_tb
  import sod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        rerr;
  int          fail_count;
  int          n_tests;

  // Device under test
  sod_top dut (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
               .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  // Clock at 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for the slave under a bounded count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      summarize();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rdat, exp);
  endtask

  // Expected minuend minus subtrahend: flags in status layout above the byte
  function automatic logic [12:0] exp_sub(input logic [7:0] m, input logic [7:0] s);
    logic [7:0] r;
    r = m - s;
    return {r[7], (m[7] ^ s[7]) & (r[7] ^ m[7]), r == 8'h00, m[3:0] >= s[3:0], m >= s, r};
  endfunction

  // File subtract with the operand placed at the address the mode must resolve
  task automatic file_sub(input logic [7:0] f, input logic d, input logic a, input logic ext, input logic [3:0] bank,
                          input logic [11:0] idx, input logic [11:0] ea, input logic [7:0] mv, input logic [7:0] av);
    logic [12:0] e;
    e = exp_sub(mv, av);
    wr(OFS_CTRL, {31'h0, ext});
    wr(OFS_BANK, {28'h0, bank});
    wr(OFS_INDEX, {20'h0, idx});
    wr(OFS_MADDR, {20'h0, ea});
    wr(OFS_MDATA, {24'h0, mv});
    wr(OFS_ACC, {24'h0, av});
    wr(OFS_STATUS, 32'h0);
    wr(OFS_INSTR, {16'h0, OPC_FILE, d, a, f});
    rd_chk("acc", OFS_ACC, {24'h0, d ? av : e[7:0]});
    rd_chk("mem", OFS_MDATA, {24'h0, d ? e[7:0] : mv});
    rd_chk("status", OFS_STATUS, {27'h0, e[12:8]});
  endtask

  logic [7:0] lit_acc [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
  logic [7:0] lit_k   [4] = '{8'h02, 8'h02, 8'h02, 8'h80};

  // Main sequence
  initial begin
    logic [12:0] e;
    fail_count = 0;
    n_tests    = 0;
    srst    = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    rd_chk("acc reset", OFS_ACC, 32'h0);
    rd_chk("bank reset", OFS_BANK, 32'h0);
    rd_chk("status reset", OFS_STATUS, 32'h0);
    // Literal subtract: positive, zero, negative and overflow results
    for (int i = 0; i < 4; i++) begin
      e = exp_sub(lit_k[i], lit_acc[i]);
      wr(OFS_ACC, {24'h0, lit_acc[i]});
      wr(OFS_STATUS, 32'h0);
      wr(OFS_INSTR, {16'h0, OPC_LIT, lit_k[i]});
      rd_chk("lit acc", OFS_ACC, {24'h0, e[7:0]});
      rd_chk("lit status", OFS_STATUS, {27'h0, e[12:8]});
    end
    // File subtract across destinations and addressing modes
    file_sub(8'h05, 1'b1, 1'b1, 1'b0, 4'h3, 12'h000, 12'h305, 8'h03, 8'h02);
    file_sub(8'h05, 1'b0, 1'b1, 1'b0, 4'h3, 12'h000, 12'h305, 8'h02, 8'h02);
    file_sub(8'h10, 1'b1, 1'b0, 1'b0, 4'h3, 12'h200, 12'h010, 8'h01, 8'h02);
    file_sub(8'h80, 1'b0, 1'b0, 1'b0, 4'h3, 12'h200, 12'hF80, 8'h80, 8'h01);
    file_sub(8'h5F, 1'b1, 1'b0, 1'b1, 4'h3, 12'h200, 12'h25F, 8'h10, 8'h01);
    file_sub(8'h60, 1'b0, 1'b0, 1'b1, 4'h3, 12'h200, 12'hF60, 8'h44, 8'h45);
    file_sub(8'h20, 1'b1, 1'b1, 1'b1, 4'h7, 12'h200, 12'h720, 8'h9A, 8'h1B);
    // Unmapped read and unknown opcode are refused
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", rdat, 32'h0);
    chk("unmapped err", {31'h0, rerr}, 32'h1);
    wr(OFS_ACC, 32'h0000_0055);
    wr(OFS_INSTR, 32'h0000_FFFF);
    chk("bad opcode err", {31'h0, rerr}, 32'h1);
    rd_chk("acc kept", OFS_ACC, 32'h0000_0055);
    rd_chk("instr reads zero", OFS_INSTR, 32'h0);
    summarize();
  end
endmodule // subtract_operand_datapath_tb
